// [common/hpi_pkg.sv]
// shared constants, types and decode helpers for the host port
package hpi_pkg;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int ADDR_W = 32;
    localparam int PAGE_W = 16;
    localparam int BE_W = 4;
    localparam int BYTE_W = 8;
    localparam int HWIL_BIT = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = ADDR_W + BE_W + DATA_W;

    // port control register fields
    localparam int CTRL_CORE_INT_BIT = 0;
    localparam int CTRL_HOST_INT_BIT = 1;

    localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OE_NONE = 32'hFFFF_FFFF;
    localparam logic [BE_W-1:0] BE_ALL_N = 4'h0;
    localparam logic [BE_W-1:0] BE_ALL = 4'hF;
    localparam logic [1:0] DS_IDLE = 2'h3;
    localparam logic [1:0] DS_ACTIVE = 2'h2;

    typedef enum logic [1:0] {
        MODE_MUX_HALF = 2'h0,
        MODE_MUX_FULL = 2'h1,
        MODE_NONMUX = 2'h2
    } hpi_mode_t;

    typedef enum logic [1:0] {
        SEL_CTRL = 2'h0,
        SEL_DATA_INC = 2'h1,
        SEL_ADDR = 2'h2,
        SEL_DATA_FIX = 2'h3
    } hpi_sel_t;

    // select and both data strobes merge into one internal strobe
    function automatic logic strobe_on(input logic cs_n, input logic [1:0] ds_n);
        return ~cs_n & (ds_n[0] ^ ds_n[1]);
    endfunction : strobe_on

    // only control and fixed data access exist without multiplexing
    function automatic logic sel_allowed(input logic [1:0] sel, input logic nonmux);
        return ~nonmux | (sel == SEL_CTRL) | (sel == SEL_DATA_FIX);
    endfunction : sel_allowed

    function automatic logic sel_is_data(input logic [1:0] sel);
        return (sel == SEL_DATA_INC) | (sel == SEL_DATA_FIX);
    endfunction : sel_is_data
endpackage : hpi_pkg

// [common/hpi_if.sv]
// pin bundle between the host and the device end of the host port
`timescale 1ns/1ps
interface hpi_if;
    logic cs_n;
    logic [1:0] ds_n;
    logic [1:0] cntl;
    logic rnw;
    logic [hpi_pkg::BE_W-1:0] be_n;
    logic [hpi_pkg::PAGE_W-1:0] ha;
    logic [hpi_pkg::DATA_W-1:0] hd_host;
    logic [hpi_pkg::DATA_W-1:0] hd_host_oe_n;
    logic [hpi_pkg::DATA_W-1:0] hd_dev;
    logic [hpi_pkg::DATA_W-1:0] hd_dev_oe_n;
    logic [hpi_pkg::DATA_W-1:0] hd;
    logic rdy;
    logic interrupt_to_host;

    // wire level per bit: the device wins a clash, undriven bits read low
    assign hd = (~hd_dev_oe_n & hd_dev) | (hd_dev_oe_n & ~hd_host_oe_n & hd_host);

    modport dev (
        input cs_n, ds_n, cntl, rnw, be_n, ha, hd,
        output hd_dev, hd_dev_oe_n, rdy, interrupt_to_host
    );

    modport host (
        output cs_n, ds_n, cntl, rnw, be_n, ha, hd_host, hd_host_oe_n,
        input hd, rdy, interrupt_to_host
    );
endinterface : hpi_if

// [src/hpi_dev.sv]
// device end of the host port: write buffer and the port logic
`timescale 1ns/1ps
module hpi_fifo #(
    parameter int W = hpi_pkg::FIFO_W,
    parameter int DEPTH = hpi_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    // depth must be a power of two for the wrap bit to work
    assign in_ready = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (clk_en && in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_ptr <= '0;
        end else if (clk_en && in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_ptr <= '0;
        end else if (clk_en && out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : hpi_fifo

// Summary of operation
// - three modes: half-word, fullword, non-multiplexed
// - select and data strobes form one strobe
// - latch control at strobe start, data at end
// - ready released only while select is active
// - access code picks control, address or data
// - non-multiplexed mode: control and fixed data only
// - host keeps bursts aligned with all bytes enabled
// - half-word mode splits each word in two
// - host drives identifier low first, high second
// - half-word reads drive upper lines unless reserved
// - optional upper address override in multiplexed modes
// - in multiplexed modes the host loads the address register first
// - single or burst data accesses after address load
// - ready held low until internal operation completes
// - core can raise an interrupt to host
// - control bit raises interrupt to the core
// - fullword mode moves each register in one cycle
// - non-multiplexed mode reaches one override-addressed page
module hpi_dev (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // host pins
    hpi_if.dev bus,
    // configuration from the core
    input wire logic [1:0] mode,
    input wire logic addr_ovr_en,
    input wire logic [hpi_pkg::BYTE_W-1:0] addr_override_top_byte,
    input wire logic [hpi_pkg::BYTE_W-1:0] addr_override_upper_mid_byte,
    input wire logic upper_gpio,
    // interrupts
    input wire logic host_int_set,
    input wire logic core_int_clear,
    output logic core_int,
    // memory port
    output logic mem_req,
    output logic mem_we,
    output logic [hpi_pkg::ADDR_W-1:0] mem_addr,
    output logic [hpi_pkg::BE_W-1:0] mem_be,
    output logic [hpi_pkg::DATA_W-1:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [hpi_pkg::DATA_W-1:0] mem_rdata
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_RDREQ = 2'h2,
        ST_HOLD = 2'h3
    } hpi_dev_state_t;

    hpi_dev_state_t state;
    hpi_dev_state_t next_state;
    logic strobe_now;
    logic strobe_q;
    logic half_mode;
    logic nonmux;
    logic [1:0] acc_sel;
    logic acc_rnw;
    logic acc_hi;
    logic [hpi_pkg::BE_W-1:0] acc_be_n;
    logic [hpi_pkg::PAGE_W-1:0] acc_page;
    logic [hpi_pkg::ADDR_W-1:0] addr_reg;
    logic [hpi_pkg::DATA_W-1:0] word_buf;
    logic interrupt_to_host_flag;
    logic acc_ok;
    logic acc_data;
    logic word_first;
    logic word_last;
    logic issue_rd;
    logic finish;
    logic [hpi_pkg::ADDR_W-1:0] eff_addr;
    logic [hpi_pkg::DATA_W-1:0] rd_word;
    logic [hpi_pkg::DATA_W-1:0] wr_word;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [hpi_pkg::FIFO_W-1:0] fifo_out_data;

    assign half_mode = (mode == hpi_pkg::MODE_MUX_HALF);
    assign nonmux = (mode == hpi_pkg::MODE_NONMUX);
    assign strobe_now = hpi_pkg::strobe_on(bus.cs_n, bus.ds_n);
    assign acc_ok = hpi_pkg::sel_allowed(acc_sel, nonmux);
    assign acc_data = acc_ok & hpi_pkg::sel_is_data(acc_sel);
    assign word_first = ~half_mode | ~acc_hi;
    assign word_last = ~half_mode | acc_hi;
    assign finish = (state == ST_HOLD) & ~strobe_now;

    // without multiplexing the override bytes and the page pins address memory
    always_comb begin
        if (nonmux) begin
            eff_addr = {addr_override_top_byte, addr_override_upper_mid_byte, acc_page};
        end else if (addr_ovr_en) begin
            eff_addr = {addr_override_top_byte, addr_override_upper_mid_byte, addr_reg[hpi_pkg::PAGE_W-1:0]};
        end else begin
            eff_addr = addr_reg;
        end
    end

    always_comb begin
        next_state = state;
        issue_rd = 1'b0;
        case (state)
            ST_IDLE: begin
                if (strobe_now && !strobe_q) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!strobe_now) begin
                    next_state = ST_IDLE;
                end else if (!acc_data) begin
                    next_state = ST_HOLD;
                end else if (acc_rnw) begin
                    // reads wait behind buffered writes so they see fresh data
                    if (!word_first) begin
                        next_state = ST_HOLD;
                    end else if (!fifo_out_valid && !mem_req) begin
                        issue_rd = 1'b1;
                        next_state = ST_RDREQ;
                    end
                end else if (!word_last || fifo_in_ready) begin
                    next_state = ST_HOLD;
                end
            end
            ST_RDREQ: begin
                if (mem_ack) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!strobe_now) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            strobe_q <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            strobe_q <= strobe_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            acc_sel <= hpi_pkg::SEL_CTRL;
            acc_rnw <= 1'b1;
            acc_hi <= 1'b0;
            acc_be_n <= hpi_pkg::BE_ALL;
            acc_page <= '0;
        end else if (clk_en && state == ST_IDLE && next_state == ST_WAIT) begin
            acc_sel <= bus.cntl;
            acc_rnw <= bus.rnw;
            acc_hi <= half_mode & bus.hd[hpi_pkg::HWIL_BIT];
            acc_be_n <= bus.be_n;
            acc_page <= bus.ha;
        end
    end

    // read value of the selected target before half selection
    always_comb begin
        case (acc_sel)
            hpi_pkg::SEL_CTRL: begin
                rd_word = hpi_pkg::DATA_ZERO;
                rd_word[hpi_pkg::CTRL_CORE_INT_BIT] = core_int;
                rd_word[hpi_pkg::CTRL_HOST_INT_BIT] = interrupt_to_host_flag;
            end
            hpi_pkg::SEL_ADDR: rd_word = acc_ok ? addr_reg : hpi_pkg::DATA_ZERO;
            default: rd_word = (state == ST_RDREQ) ? mem_rdata : word_buf;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bus.rdy <= 1'b0;
            bus.hd_dev <= hpi_pkg::DATA_ZERO;
            bus.hd_dev_oe_n <= hpi_pkg::OE_NONE;
        end else if (clk_en) begin
            bus.rdy <= ~bus.cs_n & (next_state == ST_HOLD);
            if (next_state == ST_HOLD && acc_rnw) begin
                // upper lines are driven on half-word reads unless reserved
                bus.hd_dev_oe_n <= {{hpi_pkg::HALF_W{half_mode & upper_gpio}}, {hpi_pkg::HALF_W{1'b0}}};
            end else begin
                bus.hd_dev_oe_n <= hpi_pkg::OE_NONE;
            end
            if (state != ST_HOLD && next_state == ST_HOLD) begin
                if (half_mode) begin
                    bus.hd_dev <= {{hpi_pkg::HALF_W{1'b0}}, acc_hi ? rd_word[31:16] : rd_word[15:0]};
                end else begin
                    bus.hd_dev <= rd_word;
                end
            end
        end
    end

    assign wr_word = half_mode ? {bus.hd[15:0], word_buf[15:0]} : bus.hd;
    assign fifo_in_valid = clk_en & finish & ~acc_rnw & acc_data & word_last;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            word_buf <= hpi_pkg::DATA_ZERO;
        end else if (clk_en) begin
            if (state == ST_RDREQ && mem_ack) begin
                word_buf <= mem_rdata;
            end else if (finish && !acc_rnw && acc_data && !word_last) begin
                word_buf[15:0] <= bus.hd[15:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            addr_reg <= hpi_pkg::ADDR_RESET;
        end else if (clk_en && finish && acc_ok) begin
            if (acc_sel == hpi_pkg::SEL_ADDR && !acc_rnw) begin
                if (!half_mode) begin
                    addr_reg <= bus.hd;
                end else if (acc_hi) begin
                    addr_reg[31:16] <= bus.hd[15:0];
                end else begin
                    addr_reg[15:0] <= bus.hd[15:0];
                end
            end else if (acc_sel == hpi_pkg::SEL_DATA_INC && word_last) begin
                addr_reg <= addr_reg + hpi_pkg::ADDR_STEP;
            end
        end
    end

    // a host control-bit set beats a core clear landing in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            core_int <= 1'b0;
        end else if (clk_en) begin
            if (finish && acc_sel == hpi_pkg::SEL_CTRL && !acc_rnw && bus.hd[hpi_pkg::CTRL_CORE_INT_BIT]) begin
                core_int <= 1'b1;
            end else if (core_int_clear) begin
                core_int <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            interrupt_to_host_flag <= 1'b0;
        end else if (clk_en) begin
            if (host_int_set) begin
                interrupt_to_host_flag <= 1'b1;
            end else if (finish && acc_sel == hpi_pkg::SEL_CTRL && !acc_rnw && bus.hd[hpi_pkg::CTRL_HOST_INT_BIT]) begin
                interrupt_to_host_flag <= 1'b0;
            end
        end
    end

    assign bus.interrupt_to_host = interrupt_to_host_flag;

    hpi_fifo #(
        .W(hpi_pkg::FIFO_W),
        .DEPTH(hpi_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({eff_addr[31:2], 2'b00, ~acc_be_n, wr_word}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // a pending read owns the memory port; writes drain otherwise
    assign fifo_out_ready = clk_en & ~mem_req & ~issue_rd & (state != ST_RDREQ);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= hpi_pkg::ADDR_RESET;
            mem_be <= hpi_pkg::BE_ALL;
            mem_wdata <= hpi_pkg::DATA_ZERO;
        end else if (clk_en) begin
            if (mem_req && mem_ack) begin
                mem_req <= 1'b0;
            end else if (!mem_req && issue_rd) begin
                mem_req <= 1'b1;
                mem_we <= 1'b0;
                mem_addr <= {eff_addr[31:2], 2'b00};
                mem_be <= hpi_pkg::BE_ALL;
            end else if (fifo_out_ready && fifo_out_valid) begin
                mem_req <= 1'b1;
                mem_we <= 1'b1;
                mem_addr <= fifo_out_data[67:36];
                mem_be <= fifo_out_data[35:32];
                mem_wdata <= fifo_out_data[31:0];
            end
        end
    end
endmodule : hpi_dev

// [src/hpi_host.sv]
// host end of the host port: turns commands into strobe cycles
`timescale 1ns/1ps
module hpi_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clk_en,
    // host pins
    hpi_if.host bus,
    // configuration
    input wire logic [1:0] mode,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [1:0] cmd_sel,
    input wire logic [hpi_pkg::PAGE_W-1:0] cmd_addr,
    input wire logic [hpi_pkg::BE_W-1:0] cmd_be,
    input wire logic [hpi_pkg::DATA_W-1:0] cmd_wdata,
    // response
    output logic rsp_valid,
    output logic [hpi_pkg::DATA_W-1:0] rsp_rdata
);
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SETUP = 3'h1,
        H_STROBE = 3'h2,
        H_END = 3'h3,
        H_GAP = 3'h4
    } hpi_host_state_t;

    hpi_host_state_t state;
    logic half_mode;
    logic take;
    logic wr;
    logic hi;
    logic [hpi_pkg::DATA_W-1:0] wdata;
    logic [hpi_pkg::DATA_W-1:0] rbuf;

    assign half_mode = (mode == hpi_pkg::MODE_MUX_HALF);
    assign take = cmd_valid & cmd_ready;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= H_IDLE;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= hpi_pkg::DATA_ZERO;
            wr <= 1'b0;
            hi <= 1'b0;
            wdata <= hpi_pkg::DATA_ZERO;
            rbuf <= hpi_pkg::DATA_ZERO;
            bus.cs_n <= 1'b1;
            bus.ds_n <= hpi_pkg::DS_IDLE;
            bus.cntl <= hpi_pkg::SEL_CTRL;
            bus.rnw <= 1'b1;
            bus.be_n <= hpi_pkg::BE_ALL;
            bus.ha <= '0;
            bus.hd_host <= hpi_pkg::DATA_ZERO;
            bus.hd_host_oe_n <= hpi_pkg::OE_NONE;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (take && !hpi_pkg::sel_allowed(cmd_sel, mode == hpi_pkg::MODE_NONMUX)) begin
                        // codes the page mode lacks never reach the pins
                        rsp_valid <= 1'b1;
                        rsp_rdata <= hpi_pkg::DATA_ZERO;
                    end else if (take) begin
                        cmd_ready <= 1'b0;
                        wr <= cmd_write;
                        wdata <= cmd_wdata;
                        hi <= 1'b0;
                        bus.cntl <= cmd_sel;
                        bus.rnw <= ~cmd_write;
                        bus.ha <= cmd_addr;
                        bus.be_n <= (cmd_sel == hpi_pkg::SEL_DATA_INC) ? hpi_pkg::BE_ALL_N : ~cmd_be;
                        state <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    bus.cs_n <= 1'b0;
                    if (half_mode) begin
                        bus.hd_host <= {15'h0000, hi, hi ? wdata[31:16] : wdata[15:0]};
                        bus.hd_host_oe_n <= {15'h7FFF, 1'b0, {hpi_pkg::HALF_W{~wr}}};
                    end else begin
                        bus.hd_host <= wdata;
                        bus.hd_host_oe_n <= {hpi_pkg::DATA_W{~wr}};
                    end
                    state <= H_STROBE;
                end
                H_STROBE: begin
                    bus.ds_n <= hpi_pkg::DS_ACTIVE;
                    if (bus.rdy && bus.ds_n == hpi_pkg::DS_ACTIVE) begin
                        // hold the strobe until the device says the work is done
                        if (!half_mode) begin
                            rbuf <= bus.hd;
                        end else if (hi) begin
                            rbuf[31:16] <= bus.hd[15:0];
                        end else begin
                            rbuf[15:0] <= bus.hd[15:0];
                        end
                        bus.ds_n <= hpi_pkg::DS_IDLE;
                        state <= H_END;
                    end
                end
                H_END: begin
                    // write data stays on the lines for the strobe's end
                    bus.cs_n <= 1'b1;
                    bus.hd_host_oe_n <= hpi_pkg::OE_NONE;
                    state <= H_GAP;
                end
                H_GAP: begin
                    if (half_mode && !hi) begin
                        hi <= 1'b1;
                        state <= H_SETUP;
                    end else begin
                        rsp_valid <= 1'b1;
                        rsp_rdata <= rbuf;
                        cmd_ready <= 1'b1;
                        state <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
endmodule : hpi_host

// [verif/hpi_sva.sv]
// pin-level checks between the two ends of the host port
`timescale 1ns/1ps
module hpi_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // host pins
    input wire logic cs_n,
    input wire logic [1:0] ds_n,
    input wire logic [1:0] cntl,
    input wire logic rnw,
    input wire logic [3:0] be_n,
    input wire logic [31:0] hd_dev,
    input wire logic [31:0] hd_dev_oe_n,
    input wire logic rdy,
    // configuration
    input wire logic upper_gpio
);
    logic strb;
    assign strb = ~cs_n & (ds_n[0] ^ ds_n[1]);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    rdy_needs_cs_a: assert property (rdy |-> !cs_n) else $error("ready high without select");
    rdy_rise_a: assert property ($rose(rdy) |-> strb && $past(strb)) else $error("ready rose outside strobe");
    rdy_hold_a: assert property (rdy && strb |=> rdy) else $error("ready dropped during strobe");
    rdy_release_a: assert property (rdy && !strb |=> !rdy) else $error("ready held past strobe end");
    read_drive_a: assert property (rdy && rnw |-> hd_dev_oe_n[15:0] == 16'h0000)
        else $error("read data not driven");
    idle_release_a: assert property (cs_n |-> hd_dev_oe_n == 32'hFFFF_FFFF)
        else $error("data lines driven while unselected");
    data_stable_a: assert property (rdy && $past(rdy) |-> $stable(hd_dev))
        else $error("read data moved while ready");
    burst_be_a: assert property (strb && cntl == 2'h1 |-> be_n == 4'h0)
        else $error("burst access without all bytes");
    upper_drive_a: assert property (rdy && rnw && !upper_gpio |-> hd_dev_oe_n[31:16] == 16'h0000)
        else $error("upper lines not driven on read");
    upper_release_a: assert property (upper_gpio |-> hd_dev_oe_n[31:16] == 16'hFFFF)
        else $error("reserved upper lines driven");
endmodule : hpi_sva

// [verif/host_port_interface_tb.sv]
// testbench joining both host port ends over one 64-word memory
`timescale 1ns/1ps
module host_port_interface_tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] mode = 2'h1;
    logic ovr_en = 1'b0;
    logic upper_gpio = 1'b0;
    logic [31:0] be_mask;
    logic host_int_set = 1'b0;
    logic core_int_clear = 1'b0;
    logic core_int, mem_req, mem_we, cmd_ready, rsp_valid;
    logic mem_ack = 1'b0;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, rsp_rdata, rd;
    logic [3:0] mem_be;
    logic [3:0] cmd_be = 4'hF;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [1:0] cmd_sel = 2'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic [31:0] mem [64];
    int err_count = 0;
    int n_tests = 0;
    hpi_if bus ();
    always #5 core_clk = ~core_clk;
    // only the lowest 256 bytes exist, so a missed address override loses the write
    assign mem_rdata = (mem_addr[31:8] == 24'h0) ? mem[mem_addr[7:2]] : 32'h0000_0000;
    assign be_mask = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};
    always @(negedge core_clk) begin
        mem_ack <= mem_req && !mem_ack;
        if (mem_req && !mem_ack && mem_we && mem_addr[31:8] == 24'h0) begin
            mem[mem_addr[7:2]] <= (mem[mem_addr[7:2]] & ~be_mask) | (mem_wdata & be_mask);
        end
    end
    hpi_dev u_hpi_dev (.core_clk(core_clk), .srst(srst), .clk_en(1'b1), .bus(bus.dev), .mode(mode),
        .addr_ovr_en(ovr_en), .addr_override_top_byte(8'h00), .addr_override_upper_mid_byte(8'h00),
        .upper_gpio(upper_gpio), .host_int_set(host_int_set), .core_int_clear(core_int_clear), .core_int(core_int),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    hpi_host u_hpi_host (.core_clk(core_clk), .srst(srst), .clk_en(1'b1), .bus(bus.host), .mode(mode),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
        .cmd_addr(cmd_addr), .cmd_be(cmd_be), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    hpi_sva u_hpi_sva (.core_clk(core_clk), .srst(srst), .cs_n(bus.cs_n), .ds_n(bus.ds_n), .cntl(bus.cntl),
        .rnw(bus.rnw), .be_n(bus.be_n), .hd_dev(bus.hd_dev), .hd_dev_oe_n(bus.hd_dev_oe_n), .rdy(bus.rdy),
        .upper_gpio(upper_gpio));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic access(input logic wr, input logic [1:0] sel, input logic [15:0] a, input logic [31:0] d);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_sel = sel;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        rd = rsp_rdata;
        check({31'h0, rsp_valid}, 32'h1);
    endtask : access
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        srst = 1'b0;
        access(1'b1, 2'h2, 16'h0, 32'h10);
        access(1'b1, 2'h1, 16'h0, 32'hA5A5_0001);
        access(1'b1, 2'h1, 16'h0, 32'h5A5A_0002);
        access(1'b1, 2'h2, 16'h0, 32'h10);
        access(1'b0, 2'h1, 16'h0, 32'h0);
        check(rd, 32'hA5A5_0001);
        access(1'b0, 2'h1, 16'h0, 32'h0);
        check(rd, 32'h5A5A_0002);
        check(mem[4], 32'hA5A5_0001);
        access(1'b1, 2'h2, 16'h0, 32'h14);
        access(1'b0, 2'h3, 16'h0, 32'h0);
        access(1'b0, 2'h3, 16'h0, 32'h0);
        check(rd, 32'h5A5A_0002);
        access(1'b0, 2'h2, 16'h0, 32'h0);
        check(rd, 32'h14);
        @(negedge core_clk);
        cmd_be = 4'h3;
        access(1'b1, 2'h3, 16'h0, 32'h1111_2222);
        access(1'b0, 2'h3, 16'h0, 32'h0);
        check(rd, 32'h5A5A_2222);
        $display("test fullword finished");
        access(1'b1, 2'h0, 16'h0, 32'h1);
        check({31'h0, core_int}, 32'h1);
        @(negedge core_clk);
        core_int_clear = 1'b1;
        host_int_set = 1'b1;
        cmd_be = 4'hF;
        @(negedge core_clk);
        core_int_clear = 1'b0;
        host_int_set = 1'b0;
        check({31'h0, core_int}, 32'h0);
        check({31'h0, bus.interrupt_to_host}, 32'h1);
        access(1'b0, 2'h0, 16'h0, 32'h0);
        check(rd & 32'h2, 32'h2);
        access(1'b1, 2'h0, 16'h0, 32'h2);
        check({31'h0, bus.interrupt_to_host}, 32'h0);
        $display("test interrupt finished");
        @(negedge core_clk);
        mode = 2'h0;
        upper_gpio = 1'b1;
        access(1'b1, 2'h2, 16'h0, 32'h20);
        access(1'b1, 2'h3, 16'h0, 32'hC3C3_1234);
        access(1'b0, 2'h3, 16'h0, 32'h0);
        check(rd, 32'hC3C3_1234);
        check(mem[8], 32'hC3C3_1234);
        access(1'b0, 2'h1, 16'h0, 32'h0);
        check(rd, 32'hC3C3_1234);
        access(1'b0, 2'h2, 16'h0, 32'h0);
        check(rd, 32'h24);
        $display("test halfword finished");
        @(negedge core_clk);
        mode = 2'h1;
        upper_gpio = 1'b0;
        ovr_en = 1'b1;
        access(1'b1, 2'h2, 16'h0, 32'hABCD_0030);
        access(1'b1, 2'h3, 16'h0, 32'h0BAD_F00D);
        access(1'b0, 2'h3, 16'h0, 32'h0);
        check(mem[12], 32'h0BAD_F00D);
        check(rd, 32'h0BAD_F00D);
        $display("test override finished");
        @(negedge core_clk);
        mode = 2'h2;
        ovr_en = 1'b0;
        access(1'b1, 2'h3, 16'h0034, 32'h7E57_0D0D);
        access(1'b0, 2'h3, 16'h0034, 32'h0);
        check(rd, 32'h7E57_0D0D);
        check(mem[13], 32'h7E57_0D0D);
        access(1'b1, 2'h1, 16'h0034, 32'hFFFF_FFFF);
        check(rd, 32'h0);
        access(1'b0, 2'h2, 16'h0034, 32'h0);
        check(rd, 32'h0);
        access(1'b0, 2'h3, 16'h0034, 32'h0);
        check(rd, 32'h7E57_0D0D);
        $display("test nonmux finished");
        complete_run();
    end
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
endmodule : host_port_interface_tb
